//--- hdl/dimmer_register_map.sv
// Register map of the dimmer: host request port, relay, analog and switches.
// Assumes one host request at a time, taken only while BUSY is low.
`timescale 1ns/10ps
module dimmer_register_map import dimmer_pkg::*; #(
   parameter int MS_CYCLES = MS_CYCLES_DEF,
   parameter int WDT_UNIT_CYCLES = WDT_UNIT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Host request
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [15:0] REQ_ADDR,
   input wire logic [15:0] REQ_WDATA,
   // Host answer
   output logic BUSY,
   output logic RSP_VALID,
   output logic [15:0] RSP_RDATA,
   output logic RSP_ERR,
   // Field side
   input wire logic [2:0] SWITCH_IN,
   output logic RELAY_OUT,
   output logic [15:0] ANALOG_OUT,
   // Line settings, minimum voltage and watchdog status
   output logic [7:0] NODE_ADDR,
   output logic [5:0] BAUD_CODE,
   output logic [1:0] FRAMING,
   output logic [15:0] MIN_VOLTAGE,
   output logic WDT_STATUS
);
   function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                                input logic [15:0] n);
      logic [15:0] off;
      off = a - base;
      return (a >= base) && (off < n);
   endfunction

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   rsp_state_e state_r;
   logic [15:0] ao_r, ao_safe_r, ao_pwron_r, slew_r, range_r, act_r;
   logic [15:0] node_r, line_r, rdelay_r, wdt_to_r, vmin_r, aux_r, evt_cnt_r;
   logic relay_r, rl_safe_r, rl_pwron_r, stat_r, start_r;
   logic [2:0] sw_r, sw_d_r, in_hi_r, in_lo_r;
   logic rl_hi_r, rl_lo_r;
   logic [15:0] hold_data_r;
   logic hold_err_r;
   logic delay_done, wdt_expire;

   // Request decode
   wire acc = REQ_VALID && (state_r == RSP_IDLE);
   wire wr = acc && REQ_WRITE;
   wire [15:0] a = REQ_ADDR;
   wire [15:0] d = REQ_WDATA;
   wire [1:0] bidx = 2'(a[1:0] - 2'h1);
   wire wbit = d[0];

   wire h_relay = hit(a, A_RELAY, N_ONE);
   wire h_in = hit(a, A_IN_C, N_IN) || hit(a, A_IN_D, N_IN);
   wire h_in_hi = hit(a, A_IN_HI_C, N_IN) || hit(a, A_IN_HI_D, N_IN);
   wire h_in_lo = hit(a, A_IN_LO_C, N_IN) || hit(a, A_IN_LO_D, N_IN);
   wire h_rl_hi = hit(a, A_RL_HI_C, N_ONE) || hit(a, A_RL_HI_D, N_ONE);
   wire h_rl_lo = hit(a, A_RL_LO_C, N_ONE) || hit(a, A_RL_LO_D, N_ONE);
   wire h_rl_safe = hit(a, A_RL_SAFE, N_ONE);
   wire h_rl_pwron = hit(a, A_RL_PWRON, N_ONE);
   wire h_clr = hit(a, A_LATCH_CLR, N_ONE);
   wire h_stat = hit(a, A_WDT_STAT_C, N_ONE) || hit(a, A_WDT_STAT_W, N_ONE);
   wire h_rb = (a == A_AO_RB);
   wire h_cnt = (a == A_EVT_CNT);
   wire h_ao = (a == A_AO);
   wire h_ao_safe = (a == A_AO_SAFE);
   wire h_act = (a == A_OFF_ACT);
   wire h_ao_pwron = (a == A_AO_PWRON);
   wire h_slew = (a == A_AO_SLEW);
   wire h_range = (a == A_AO_RANGE);
   wire h_fw_lo = (a == A_FW_LO);
   wire h_fw_hi = (a == A_FW_HI);
   wire h_nm_lo = (a == A_NAME_LO);
   wire h_nm_hi = (a == A_NAME_HI);
   wire h_node = (a == A_NODE);
   wire h_line = (a == A_LINE);
   wire h_rdelay = (a == A_RDELAY);
   wire h_wdt = (a == A_WDT_TO);
   wire h_vmin = (a == A_VMIN);
   wire h_aux = (a == A_AUX);

   // Read side
   wire h_ro = h_in || h_in_hi || h_in_lo || h_rl_hi || h_rl_lo || h_rb || h_cnt
               || h_fw_lo || h_fw_hi || h_nm_lo || h_nm_hi;
   wire h_rw_bit = h_relay || h_rl_safe || h_rl_pwron || h_stat;
   wire h_rw_word = h_ao || h_ao_safe || h_act || h_ao_pwron || h_slew || h_range
                    || h_node || h_line || h_rdelay || h_wdt || h_vmin || h_aux;
   wire rd_ok = h_ro || h_rw_bit || h_rw_word;
   wire [15:0] rd_data =
      h_relay ? {15'h0000, relay_r} : // R6
      h_in ? {15'h0000, sw_r[bidx]} : // R2
      h_in_hi ? {15'h0000, in_hi_r[bidx]} : // R3
      h_in_lo ? {15'h0000, in_lo_r[bidx]} :
      h_rl_hi ? {15'h0000, rl_hi_r} : // R4
      h_rl_lo ? {15'h0000, rl_lo_r} : // R5
      h_rl_safe ? {15'h0000, rl_safe_r} : // R7
      h_rl_pwron ? {15'h0000, rl_pwron_r} : // R8
      h_stat ? {15'h0000, stat_r} : // R16
      h_rb ? ao_r : // R1
      h_cnt ? evt_cnt_r :
      h_ao ? ao_r :
      h_ao_safe ? ao_safe_r :
      h_act ? act_r :
      h_ao_pwron ? ao_pwron_r :
      h_slew ? slew_r :
      h_range ? range_r :
      h_fw_lo ? FW_LO_VAL :
      h_fw_hi ? FW_HI_VAL :
      h_nm_lo ? NAME_LO_VAL :
      h_nm_hi ? NAME_HI_VAL :
      h_node ? node_r :
      h_line ? line_r :
      h_rdelay ? rdelay_r :
      h_wdt ? wdt_to_r :
      h_vmin ? vmin_r :
      h_aux ? aux_r : ZERO16;

   // Write side, with range checks
   wire ok_node = in_range(d, NODE_MIN, NODE_MAX); // R18
   wire ok_baud = (d[BAUD_MSB:BAUD_LSB] >= BAUD_MIN) // R9
                  && (d[BAUD_MSB:BAUD_LSB] <= BAUD_MAX);
   wire ok_line = ok_baud && (d[15:FRAME_MSB+1] == 8'h00); // R10
   wire ok_rdelay = (d <= RDELAY_MAX); // R11
   wire ok_wdt = (d <= WDT_MAX); // R12
   wire ok_vmin = in_range(d, VMIN_MIN, VMIN_MAX); // R13
   wire ok_act = (d <= ACT_MAX);
   wire bad_val = (h_node && !ok_node) || (h_line && !ok_line)
                  || (h_rdelay && !ok_rdelay) || (h_wdt && !ok_wdt)
                  || (h_vmin && !ok_vmin) || (h_act && !ok_act);
   wire wr_ok = h_rw_bit || h_rw_word || h_clr;
   wire req_err = REQ_WRITE ? (!wr_ok || bad_val) : !rd_ok;
   wire wr_go = wr && !req_err;

   // Switch edges
   wire [2:0] rise = sw_r & ~sw_d_r;
   wire [2:0] fall = ~sw_r & sw_d_r;
   wire off_evt = (fall[1] && !sw_r[2]) || (fall[2] && !sw_r[1]);
   wire on_evt = rise[1] || rise[2];
   wire [15:0] dim_val = 16'(act_r * DIM_STEP);

   // Next relay and analog values
   wire relay_nxt =
      start_r ? rl_pwron_r : // R8
      (wr_go && h_relay) ? wbit : // R6
      wdt_expire ? rl_safe_r : // R17
      off_evt ? (act_r != ZERO16) : // R14
      on_evt ? 1'b1 : relay_r;
   wire [15:0] ao_nxt =
      start_r ? ao_pwron_r :
      (wr_go && h_ao) ? d :
      wdt_expire ? ao_safe_r : // R17
      (off_evt && act_r != ZERO16) ? dim_val : ao_r; // R14

   // Latch clear and set, set wins
   wire clr = wr_go && h_clr && wbit; // R15
   wire [2:0] in_hi_nxt = (clr ? 3'h0 : in_hi_r) | sw_r; // R3
   wire [2:0] in_lo_nxt = (clr ? 3'h0 : in_lo_r) | ~sw_r;
   wire rl_hi_nxt = (clr ? 1'b0 : rl_hi_r) | relay_r; // R4
   wire rl_lo_nxt = (clr ? 1'b0 : rl_lo_r) | ~relay_r; // R5
   wire stat_nxt = wdt_expire || (stat_r && !(wr_go && h_stat && wbit)); // R16

   reply_delay_timer #(.MS_CYCLES(MS_CYCLES)) u_delay (
      .clk(CLOCK),
      .rst_n(RST_N),
      .start(acc),
      .delay_ms(rdelay_r[4:0]), // R11
      .done(delay_done)
   );

   host_watchdog #(.UNIT_CYCLES(WDT_UNIT_CYCLES)) u_wdt (
      .clk(CLOCK),
      .rst_n(RST_N),
      .kick(acc),
      .timeout(wdt_to_r[7:0]), // R12
      .expire(wdt_expire)
   );

   // Answer sequencing
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= RSP_IDLE;
         hold_data_r <= ZERO16;
         hold_err_r <= 1'b0;
      end else begin
         unique case (state_r)
            RSP_IDLE: begin
               if (acc) begin
                  state_r <= RSP_WAIT;
                  hold_data_r <= REQ_WRITE ? ZERO16 : rd_data;
                  hold_err_r <= req_err;
               end
            end
            RSP_WAIT: begin
               if (delay_done)
                  state_r <= RSP_SEND; // R11
            end
            RSP_SEND: begin
               state_r <= RSP_IDLE;
            end
         endcase
      end
   end

   // Answer outputs
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUSY <= 1'b0;
         RSP_VALID <= 1'b0;
         RSP_RDATA <= ZERO16;
         RSP_ERR <= 1'b0;
      end else begin
         BUSY <= (state_r == RSP_IDLE) ? acc : (state_r != RSP_SEND);
         RSP_VALID <= (state_r == RSP_SEND);
         RSP_RDATA <= (state_r == RSP_SEND) ? hold_data_r : ZERO16;
         RSP_ERR <= (state_r == RSP_SEND) && hold_err_r;
      end
   end

   // Relay, analog and latches
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         start_r <= 1'b1;
         relay_r <= RELAY_RST;
         ao_r <= AO_RST;
         sw_r <= 3'h0;
         sw_d_r <= 3'h0;
         in_hi_r <= 3'h0;
         in_lo_r <= 3'h0;
         rl_hi_r <= 1'b0;
         rl_lo_r <= 1'b0;
         stat_r <= 1'b0;
         evt_cnt_r <= ZERO16;
      end else begin
         start_r <= 1'b0;
         relay_r <= relay_nxt;
         ao_r <= ao_nxt;
         sw_r <= SWITCH_IN; // R2
         sw_d_r <= sw_r;
         in_hi_r <= in_hi_nxt;
         in_lo_r <= in_lo_nxt;
         rl_hi_r <= rl_hi_nxt;
         rl_lo_r <= rl_lo_nxt;
         stat_r <= stat_nxt;
         evt_cnt_r <= evt_cnt_r + {15'h0000, rise[0]};
      end
   end

   // Bit settings
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rl_safe_r <= RL_SAFE_RST;
         rl_pwron_r <= RL_PWRON_RST;
      end else begin
         if (wr_go && h_rl_safe)
            rl_safe_r <= wbit; // R7
         if (wr_go && h_rl_pwron)
            rl_pwron_r <= wbit; // R8
      end
   end

   // Word settings
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ao_safe_r <= AO_RST;
         ao_pwron_r <= AO_RST;
         slew_r <= ZERO16;
         range_r <= RANGE_RST;
         act_r <= ZERO16;
         node_r <= NODE_RST;
         line_r <= LINE_RST;
         rdelay_r <= RDELAY_RST;
         wdt_to_r <= WDT_TO_RST;
         vmin_r <= VMIN_RST;
         aux_r <= ZERO16;
      end else if (wr_go) begin
         if (h_ao_safe)
            ao_safe_r <= d;
         if (h_ao_pwron)
            ao_pwron_r <= d;
         if (h_slew)
            slew_r <= d;
         if (h_range)
            range_r <= d;
         if (h_act)
            act_r <= d; // R14
         if (h_node)
            node_r <= d;
         if (h_line)
            line_r <= d; // R9
         if (h_rdelay)
            rdelay_r <= d; // R11
         if (h_wdt)
            wdt_to_r <= d; // R12
         if (h_vmin)
            vmin_r <= d; // R13
         if (h_aux)
            aux_r <= d;
      end
   end

   // Settings outputs
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         NODE_ADDR <= NODE_RST[7:0];
         BAUD_CODE <= LINE_RST[BAUD_MSB:BAUD_LSB];
         FRAMING <= LINE_RST[FRAME_MSB:FRAME_LSB];
         MIN_VOLTAGE <= VMIN_RST;
      end else begin
         NODE_ADDR <= node_r[7:0];
         BAUD_CODE <= line_r[BAUD_MSB:BAUD_LSB]; // R9
         FRAMING <= line_r[FRAME_MSB:FRAME_LSB]; // R10
         MIN_VOLTAGE <= vmin_r; // R13
      end
   end

   assign RELAY_OUT = relay_r;
   assign ANALOG_OUT = ao_r;
   assign WDT_STATUS = stat_r;
endmodule

//--- hdl/dimmer_pkg.sv
// Constants, register numbers and limits of the dimmer register map.
// Assumes a 25 MHz clock; register numbers are the host-visible addresses.
// Behaviour
// [R1] Analog readback register returns the analog value now driven; read-only.
// [R2] Three switch input states readable as bits in coil and discrete ranges.
// [R3] Per-input high latch records input seen on since last clear.
// [R4] Relay high latch records relay seen on since last clear.
// [R5] Relay low latch records relay seen off since last clear.
// [R6] Relay coil is read/write: host sets it, read returns commanded state.
// [R7] Relay safe bit is read/write and keeps the last written value.
// [R8] Relay power-on bit is read/write; relay takes it after reset.
// [R9] Settings bits 5:0 pick bit rate, codes 0x03..0x0A, 1200..115200.
// [R10] Settings bits 7:6 pick framing: N1, N2, E1, O1.
// [R11] Each reply waits a programmed 0..30 ms.
// [R12] Host watchdog timeout 0..255 in tenths of a second, read/write.
// [R13] Minimum output voltage read/write, whole volts one to nine.
// [R14] Switch 1/2 turning off applies action: 0 relay off, 1..10 dim level.
// [R15] Writing one to the latch-clear coil clears all latches; write-only.
// [R16] Watchdog status bit readable; writing one clears it.
// [R17] Watchdog expiry drives relay and analog to safe values, sets status.
// [R18] Out-of-range writes are refused and the old value kept.
package dimmer_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_TIME_NS = 1000000;
   localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int WDT_UNIT_NS = 100000000;
   localparam int WDT_UNIT_CYCLES_DEF = WDT_UNIT_NS / CLK_PERIOD_NS;
   // Coils
   localparam logic [15:0] A_RELAY = 16'h0001;
   localparam logic [15:0] A_IN_C = 16'h0021;
   localparam logic [15:0] A_IN_HI_C = 16'h0041;
   localparam logic [15:0] A_RL_HI_C = 16'h0049;
   localparam logic [15:0] A_IN_LO_C = 16'h0061;
   localparam logic [15:0] A_RL_LO_C = 16'h0069;
   localparam logic [15:0] A_RL_SAFE = 16'h0081;
   localparam logic [15:0] A_RL_PWRON = 16'h00A1;
   localparam logic [15:0] A_LATCH_CLR = 16'h0108;
   localparam logic [15:0] A_WDT_STAT_C = 16'h010E;
   // Discretes
   localparam logic [15:0] A_IN_D = 16'h2731;
   localparam logic [15:0] A_IN_HI_D = 16'h2751;
   localparam logic [15:0] A_RL_HI_D = 16'h2759;
   localparam logic [15:0] A_IN_LO_D = 16'h2771;
   localparam logic [15:0] A_RL_LO_D = 16'h2779;
   // Input and holding registers
   localparam logic [15:0] A_AO_RB = 16'h7571;
   localparam logic [15:0] A_EVT_CNT = 16'h75B1;
   localparam logic [15:0] A_AO = 16'h9C61;
   localparam logic [15:0] A_AO_SAFE = 16'h9CA1;
   localparam logic [15:0] A_OFF_ACT = 16'h9CE1;
   localparam logic [15:0] A_AO_PWRON = 16'h9D01;
   localparam logic [15:0] A_AO_SLEW = 16'h9D61;
   localparam logic [15:0] A_AO_RANGE = 16'h9DE1;
   localparam logic [15:0] A_FW_LO = 16'h9E21;
   localparam logic [15:0] A_FW_HI = 16'h9E22;
   localparam logic [15:0] A_NAME_LO = 16'h9E23;
   localparam logic [15:0] A_NAME_HI = 16'h9E24;
   localparam logic [15:0] A_NODE = 16'h9E25;
   localparam logic [15:0] A_LINE = 16'h9E26;
   localparam logic [15:0] A_RDELAY = 16'h9E28;
   localparam logic [15:0] A_WDT_TO = 16'h9E29;
   localparam logic [15:0] A_WDT_STAT_W = 16'h9E2C;
   localparam logic [15:0] A_VMIN = 16'h9E2E;
   localparam logic [15:0] A_AUX = 16'h9E32;
   // Counts of multi-channel ranges
   localparam logic [15:0] N_IN = 16'h0003;
   localparam logic [15:0] N_ONE = 16'h0001;
   // Valid ranges
   localparam logic [15:0] NODE_MIN = 16'h0001;
   localparam logic [15:0] NODE_MAX = 16'h00F7;
   localparam logic [5:0] BAUD_MIN = 6'h03;
   localparam logic [5:0] BAUD_MAX = 6'h0A;
   localparam logic [15:0] RDELAY_MAX = 16'h001E;
   localparam logic [15:0] WDT_MAX = 16'h00FF;
   localparam logic [15:0] VMIN_MIN = 16'h0001;
   localparam logic [15:0] VMIN_MAX = 16'h0009;
   localparam logic [15:0] ACT_MAX = 16'h000A;
   localparam logic [15:0] DIM_STEP = 16'h1999;
   // Settings word fields
   localparam int BAUD_LSB = 0;
   localparam int BAUD_MSB = 5;
   localparam int FRAME_LSB = 6;
   localparam int FRAME_MSB = 7;
   // Reset values
   localparam logic RELAY_RST = 1'b0;
   localparam logic RL_SAFE_RST = 1'b0;
   localparam logic RL_PWRON_RST = 1'b0;
   localparam logic [15:0] AO_RST = 16'h0000;
   localparam logic [15:0] NODE_RST = 16'h0001;
   localparam logic [15:0] LINE_RST = 16'h0006;
   localparam logic [15:0] RDELAY_RST = 16'h0000;
   localparam logic [15:0] WDT_TO_RST = 16'h0000;
   localparam logic [15:0] VMIN_RST = 16'h0001;
   localparam logic [15:0] RANGE_RST = 16'h0002;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // Identity words, arbitrary values
   localparam logic [15:0] FW_LO_VAL = 16'h0101;
   localparam logic [15:0] FW_HI_VAL = 16'h0000;
   localparam logic [15:0] NAME_LO_VAL = 16'h00A5;
   localparam logic [15:0] NAME_HI_VAL = 16'h005A;
   // Framing codes in settings bits 7:6
   typedef enum logic [1:0] {FRAME_N1, FRAME_N2, FRAME_E1, FRAME_O1} framing_e;
   typedef enum logic [1:0] {RSP_IDLE, RSP_WAIT, RSP_SEND} rsp_state_e;
endpackage

//--- hdl/reply_delay_timer.sv
// Millisecond countdown between accepting a request and answering it.
// Assumes one start pulse at a time; done pulses once per start.
`timescale 1ns/10ps
module reply_delay_timer import dimmer_pkg::*; #(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic [4:0] delay_ms,
   output logic done
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   logic [PW-1:0] pre_r;
   logic [4:0] ms_r;
   logic run_r;
   wire pre_end = (pre_r == PW'(MS_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= '0;
         ms_r <= '0;
         run_r <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            run_r <= 1'b1;
            ms_r <= delay_ms;
            pre_r <= '0;
         end else if (run_r) begin
            if (ms_r == 5'h00) begin
               run_r <= 1'b0;
               done <= 1'b1;
            end else if (pre_end) begin
               pre_r <= '0;
               ms_r <= ms_r - 5'h01;
            end else begin
               pre_r <= pre_r + 1'b1;
            end
         end
      end
   end
endmodule

//--- hdl/host_watchdog.sv
// Host watchdog: counts tenths of a second since the last host request.
// Timeout zero disables it; it fires once until the next kick.
`timescale 1ns/10ps
module host_watchdog import dimmer_pkg::*; #(
   parameter int UNIT_CYCLES = WDT_UNIT_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic kick,
   input wire logic [7:0] timeout,
   output logic expire
);
   localparam int PW = $clog2(UNIT_CYCLES + 1);
   logic [PW-1:0] pre_r;
   logic [7:0] units_r;
   logic fired_r;
   wire pre_end = (pre_r == PW'(UNIT_CYCLES - 1));
   wire armed = (timeout != 8'h00) && !fired_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= '0;
         units_r <= 8'h00;
         fired_r <= 1'b0;
         expire <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (kick || !armed) begin
            pre_r <= '0;
            units_r <= 8'h00;
            if (kick)
               fired_r <= 1'b0;
         end else if (units_r == timeout) begin
            fired_r <= 1'b1;
            expire <= 1'b1; // R17
         end else if (pre_end) begin
            pre_r <= '0;
            units_r <= units_r + 8'h01;
         end else begin
            pre_r <= pre_r + 1'b1;
         end
      end
   end
endmodule

//--- sim/dimmer_register_map_asserts.sv
// Checker of host port timing and settings outputs.
// Assumes a bind to the map, ports by name.
`timescale 1ns/10ps
module dimmer_register_map_asserts (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Host port
   input wire logic REQ_VALID,
   input wire logic BUSY,
   input wire logic RSP_VALID,
   input wire logic [15:0] RSP_RDATA,
   input wire logic RSP_ERR,
   // Settings
   input wire logic [7:0] NODE_ADDR,
   input wire logic [5:0] BAUD_CODE,
   input wire logic [1:0] FRAMING,
   input wire logic [15:0] MIN_VOLTAGE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   sequence s_take;
      REQ_VALID && !BUSY && !RSP_VALID;
   endsequence
   sequence s_wait;
      BUSY [*3] ##[1:130] RSP_VALID;
   endsequence
   AST_TAKE: assert property (s_take |=> BUSY)
      else $error("request not taken");
   AST_ANSWER: assert property (s_take |=> s_wait)
      else $error("answer missing or early");
   AST_HOLD: assert property (BUSY |=> BUSY || RSP_VALID)
      else $error("busy dropped before answer");
   AST_END: assert property (RSP_VALID |=> !RSP_VALID && !BUSY)
      else $error("answer not closed");
   AST_ERR: assert property (RSP_ERR |-> RSP_VALID)
      else $error("error flag outside answer");
   AST_IDLE: assert property (!RSP_VALID |-> RSP_RDATA == 16'h0000)
      else $error("read data outside answer");
   AST_CFG: assert property ($changed(FRAMING) || $changed(BAUD_CODE) |-> BUSY)
      else $error("settings changed while idle");
   AST_BAUD: assert property (BAUD_CODE inside {[6'h03:6'h0A]})
      else $error("bit rate code out of range");
   AST_NODE: assert property (NODE_ADDR inside {[8'h01:8'hF7]})
      else $error("node address out of range");
   AST_VMIN: assert property (MIN_VOLTAGE inside {[16'h0001:16'h0009]})
      else $error("minimum voltage out of range");
endmodule
bind dimmer_register_map dimmer_register_map_asserts u_asserts (
   .CLOCK(CLOCK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .BUSY(BUSY),
   .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .RSP_ERR(RSP_ERR),
   .NODE_ADDR(NODE_ADDR), .BAUD_CODE(BAUD_CODE), .FRAMING(FRAMING),
   .MIN_VOLTAGE(MIN_VOLTAGE)
);

//--- sim/host_model.sv
// Host side: one register request at a time.
// Assumes a one-cycle answer pulse.
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic clk,
   // Request
   output logic req_valid,
   output logic req_write,
   output logic [15:0] req_addr,
   output logic [15:0] req_wdata,
   // Answer
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_rdata,
   input wire logic rsp_err
);
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
   end
   // n: edges to answer
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
         output logic [15:0] q, output logic e, output int n);
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr <= ~a;
      req_wdata <= ~d;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 300);
      q = rsp_rdata;
      e = rsp_err;
   endtask
endmodule

//--- sim/modbus_dimmer_register_map_tb_top.sv
// Bench: host model and register model against the map.
// Assumes short time units, set below.
`timescale 1ns/10ps
module modbus_dimmer_register_map_tb_top import dimmer_pkg::*; ;
   localparam int MSC = 4;
   logic clk, rst_n, rsp_valid, rsp_err, relay, wdt, req_valid, req_write, busy, e;
   logic [15:0] req_addr, req_wdata, rsp_rdata, aout, vmin, q;
   logic [7:0] node;
   logic [5:0] baud;
   logic [2:0] sw;
   logic [1:0] frm;
   logic [31:0] rs = 32'h00000025;
   int n_mismatch = 0, checks_done = 0, lat, i, mdl[int];
   logic [15:0] rv[] = '{A_RELAY, A_RL_SAFE, A_RL_PWRON, A_AO, A_AO_SAFE, A_OFF_ACT, A_AO_PWRON,
      A_AO_SLEW, A_RDELAY, A_WDT_TO, A_AUX, A_NODE, A_LINE, A_VMIN, A_AO_RANGE};
   logic [15:0] tv[] = '{A_LINE, 16'h0002, A_LINE, 16'h000B, A_LINE, 16'h0106,
      A_NODE, 16'h0000, A_NODE, 16'h00F8, A_NODE, 16'h00F7, A_VMIN, 16'h0000,
      A_VMIN, 16'h000A, A_VMIN, 16'h0009, A_RDELAY, 16'h001F, A_WDT_TO, 16'h0100,
      A_OFF_ACT, 16'h000B, A_AUX, 16'h5A5A};
   logic [15:0] acts[] = '{16'h000A, 16'h0000, 16'h0001};
   dimmer_register_map #(.MS_CYCLES(MSC), .WDT_UNIT_CYCLES(8)) DUT (
      .CLOCK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
      .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BUSY(busy), .RSP_VALID(rsp_valid),
      .RSP_RDATA(rsp_rdata), .RSP_ERR(rsp_err), .SWITCH_IN(sw), .RELAY_OUT(relay),
      .ANALOG_OUT(aout), .NODE_ADDR(node), .BAUD_CODE(baud), .FRAMING(frm),
      .MIN_VOLTAGE(vmin), .WDT_STATUS(wdt));
   host_model hm (.clk(clk), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Refusal from the valid ranges
   function automatic logic bad(input logic [15:0] a, input logic [15:0] d);
      case (a)
         A_NODE: return d < NODE_MIN || d > NODE_MAX;
         A_LINE: return d[15:8] != 8'h00 || d[5:0] < BAUD_MIN || d[5:0] > BAUD_MAX;
         A_RDELAY: return d > RDELAY_MAX;
         A_WDT_TO: return d > WDT_MAX;
         A_VMIN: return d < VMIN_MIN || d > VMIN_MAX;
         A_OFF_ACT: return d > ACT_MAX;
         A_LATCH_CLR, A_WDT_STAT_C: return 1'b0;
         default: return !mdl.exists(a);
      endcase
   endfunction
   task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d,
         input logic [15:0] xd, input logic xe);
      hm.xfer(w, a, d, q, e, lat);
      if (lat >= 300) begin
         n_mismatch++;
         give_verdict();
      end
      chk("rdata", xd, q);
      chk("err", 16'(xe), 16'(e));
      chk("latency", 16'(4 + mdl[A_RDELAY] * MSC), 16'(lat));
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic b;
      b = bad(a, d);
      op(1'b1, a, d, 16'h0000, b);
      if (!b && mdl.exists(a)) mdl[a] = (a < 16'h2000) ? d[0] : d;
   endtask
   task automatic rx(input logic [15:0] a, input logic [15:0] x);
      op(1'b0, a, 16'h0000, x, 1'b0);
   endtask
   task automatic rd(input logic [15:0] a);
      rx(a, 16'(mdl[a]));
   endtask
   initial begin
      rst_n = 1'b0;
      sw = 3'b000;
      foreach (rv[k]) mdl[rv[k]] = 16'h0000;
      mdl[A_NODE] = 16'h0001;
      mdl[A_LINE] = 16'h0006;
      mdl[A_VMIN] = 16'h0001;
      mdl[A_AO_RANGE] = 16'h0002;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      foreach (mdl[k]) rd(16'(k));
      chk("node", 16'h0001, {8'h00, node});
      $display("Test reset done");
      for (i = 3; i <= 10; i++) begin
         wr(A_LINE, 16'(i % 4 * 64 + i));
         chk("baud", 16'(i), {10'h000, baud});
         chk("framing", 16'(i % 4), {14'h0000, frm});
      end
      for (i = 0; i < $size(tv); i += 2) begin
         wr(tv[i], tv[i+1]);
         rd(tv[i]);
      end
      chk("vmin", 16'h0009, vmin);
      op(1'b0, 16'h0002, 16'h0000, 16'h0000, 1'b1);
      op(1'b1, A_AO_RB, 16'h0001, 16'h0000, 1'b1);
      op(1'b0, A_LATCH_CLR, 16'h0000, 16'h0000, 1'b1);
      wr(A_RDELAY, 16'h0002);
      rd(A_LINE);
      wr(A_RDELAY, 16'h0000);
      $display("Test settings done");
      wr(A_RELAY, 16'h0001);
      chk("relay", 16'h0001, 16'(relay));
      wr(A_LATCH_CLR, 16'h0001);
      rx(A_RL_HI_C, 16'h0001);
      rx(A_RL_LO_D, 16'h0000);
      wr(A_RELAY, 16'h0000);
      rx(A_RL_LO_C, 16'h0001);
      rx(A_RL_HI_D, 16'h0001);
      wr(A_RL_SAFE, 16'h0001);
      rd(A_RL_SAFE);
      wr(A_RL_PWRON, 16'h0001);
      rd(A_RL_PWRON);
      rs = xs(rs);
      wr(A_AO, rs[15:0]);
      chk("analog", rs[15:0], aout);
      rx(A_AO_RB, rs[15:0]);
      $display("Test outputs done");
      rs = xs(rs);
      sw <= rs[2:0];
      repeat (4) @(posedge clk);
      wr(A_LATCH_CLR, 16'h0001);
      for (i = 0; i < 3; i++) begin
         rx(A_IN_C + 16'(i), 16'(rs[i]));
         rx(A_IN_D + 16'(i), 16'(rs[i]));
         rx(A_IN_HI_C + 16'(i), 16'(rs[i]));
         rx(A_IN_LO_D + 16'(i), 16'(!rs[i]));
      end
      foreach (acts[k]) begin
         wr(A_OFF_ACT, acts[k]);
         sw <= 3'b010;
         repeat (4) @(posedge clk);
         sw <= 3'b000;
         repeat (6) @(posedge clk);
         chk("relay", 16'(acts[k] != 16'h0000), 16'(relay));
         if (acts[k] != 16'h0000) chk("analog", acts[k] * DIM_STEP, aout);
      end
      $display("Test switches done");
      wr(A_AO_SAFE, 16'h0BEE);
      wr(A_RELAY, 16'h0000);
      wr(A_WDT_TO, 16'h0002);
      for (i = 0; wdt !== 1'b1 && i < 200; i++) @(posedge clk);
      if (i >= 200) begin
         n_mismatch++;
         give_verdict();
      end
      chk("expiry", 16'h0001, 16'(i > 8 && i < 24));
      repeat (2) @(posedge clk);
      chk("relay", 16'h0001, 16'(relay));
      chk("analog", 16'h0BEE, aout);
      wr(A_WDT_STAT_C, 16'h0001);
      chk("status", 16'h0000, 16'(wdt));
      wr(A_WDT_TO, 16'h0000);
      $display("Test watchdog done");
      give_verdict();
   end
endmodule
